/* File: include/incr_exec_pkg.sv */
// Constants and types for the increment-and-skip execution block.
// Assumes one 200 MHz clock; an instruction cycle is four clocks.
// Contract
// [RQ1] Increment adds one, updates all five flags
// [RQ2] Destination bit: clear to W, set to file
// [RQ3] Bank bit clear selects access bank
// [RQ4] Bank bit set uses bank select register
// [RQ5] Extended set, low offsets use indexed literal
// [RQ6] Skip-if-zero decodes 0011 11da, keeps status
// [RQ7] Skip-if-nonzero decodes 0100 10da, keeps status
// [RQ8] Zero result discards follower for skip-zero
// [RQ9] Nonzero result discards follower for skip-nonzero
// [RQ10] Skip over one word adds one cycle
// [RQ11] Skip over two words: three cycles total
// [RQ12] Skip over three words: four cycles total
// [RQ13] Branch loads 20-bit literal, two cycles
// [RQ14] Increment: one word, four phases, one cycle
package incr_exec_pkg;

  ////////////////////////////////////////////////////////////////////
  // Phases of the instruction cycle
  localparam logic [1:0] PH_DECODE  = 2'h0;
  localparam logic [1:0] PH_READ    = 2'h1;
  localparam logic [1:0] PH_PROCESS = 2'h2;
  localparam logic [1:0] PH_WRITE   = 2'h3;

  ////////////////////////////////////////////////////////////////////
  // Opcode fields (upper six bits of the first word; branch uses eight, plus a second-word prefix)
  localparam logic [5:0] OPC_INC_FILE  = 6'h0a; // 0010 10
  localparam logic [5:0] OPC_INC_SZERO = 6'h0f; // 0011 11
  localparam logic [5:0] OPC_INC_SNZ   = 6'h12; // 0100 10
  localparam logic [7:0] OPC_BRANCH_W1 = 8'hef; // first branch word
  localparam logic [3:0] OPC_BRANCH_W2 = 4'hf;  // second word prefix

  ////////////////////////////////////////////////////////////////////
  // Addressing
  localparam int         ADDR_W       = 14;
  localparam logic [7:0] LIT_LIMIT    = 8'h5f;  // indexed up to 95
  localparam logic [7:0] ACC_SPLIT    = 8'h60;  // access bank split
  localparam logic [5:0] ACC_LO_BANK  = 6'h00;  // access low half
  localparam logic [5:0] ACC_HI_BANK  = 6'h3f;  // access high half
  localparam int         PC_W         = 21;

  ////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] BYTE_RST     = 8'h00;
  localparam logic [1:0] NOP_ONE      = 2'h1;

  // Status flags carried together
  typedef struct packed {
    logic n;
    logic overflow_bit;
    logic z;
    logic half_carry_bit;
    logic c;
  } status_t;

  // First instruction word of a byte-oriented op
  typedef struct packed {
    logic [5:0] opc;
    logic       dest;
    logic       bank;
    logic [7:0] f;
  } byte_op_t;

  // Decoded operation kind
  typedef enum logic [2:0] {
    K_NONE, K_INC, K_SZ, K_SNZ, K_BR
  } op_kind_t;

  // Sequencer state
  typedef enum logic {ST_RUN, ST_NOP} exec_state_t;

endpackage

/* File: src/inc_alu.sv */
// Combinational incrementer with full flag generation.
// Assumes the caller decides whether the flags are kept.
`timescale 1ns/1ps
module inc_alu (
  // Operand in
  input  wire logic [7:0]             i_operand,
  // Result and flags out
  output logic [7:0]                  o_result,
  output incr_exec_pkg::status_t      o_flags
);
  import incr_exec_pkg::*;

  // Sum with carry out of bit 7
  logic [8:0] sum;
  assign sum      = {1'b0, i_operand} + 9'h001;
  assign o_result = sum[7:0];

  // Flag equations for an add of one
  always_comb begin
    o_flags.c  = sum[8];                          // [RQ1]
    o_flags.half_carry_bit = (i_operand[3:0] == 4'hf); // Nibble carry
    o_flags.n  = sum[7];
    o_flags.overflow_bit   = (i_operand == 8'h7f);     // Positive wrap
    o_flags.z  = (sum[7:0] == 8'h00);
  end

endmodule

/* File: src/incr_skip_exec.sv */
// Executes increment, increment-skip and branch instructions.
// Assumes fetch presents words on the same clock and data
// memory answers a read one clock after the read strobe.
`timescale 1ns/1ps
module incr_skip_exec (
  // Clock and reset
  input  wire logic                         i_sys_clk,
  input  wire logic                         i_rst,
  // Fetch side
  input  wire logic                         i_instr_valid,
  input  wire incr_exec_pkg::byte_op_t      i_instr,
  input  wire logic [15:0]                  i_instr_hi,
  input  wire logic [1:0]                   i_follow_words,
  output logic                              o_take,
  output logic                              o_busy,
  output logic                              o_discard,
  output logic [1:0]                        o_phase,
  // Configuration
  input  wire logic                         i_ext_en,
  input  wire logic [5:0]                   i_bank_select_register,
  input  wire logic [13:0]                  i_fsr2,
  // Data memory
  output logic [13:0]                       o_mem_addr,
  output logic                              o_mem_rd,
  input  wire logic [7:0]                   i_mem_rdata,
  output logic                              o_mem_wr,
  output logic [7:0]                        o_mem_wdata,
  // Core registers
  output logic [7:0]                        o_wreg,
  output logic                              o_wreg_we,
  output incr_exec_pkg::status_t            o_status,
  output logic [20:0]                       o_pc,
  output logic                              o_pc_load
);
  import incr_exec_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // Declarations
  logic [1:0]       phase_r;      // Free-running phase counter
  exec_state_t      state_r;      // Run or inserted no-operation
  logic [1:0]       nop_left_r;   // No-operation cycles still due
  logic             valid_r;      // An instruction is executing
  op_kind_t         kind_r;       // Kind of that instruction
  op_kind_t         kind_nxt;     // Kind decoded from fetch
  byte_op_t         instr_r;      // First word held for the cycle
  logic [19:0]      lit_r;        // Branch literal
  logic [7:0]       operand_r;    // Value read from file
  logic [7:0]       result_r;     // Last increment result
  logic [7:0]       alu_res;      // Incrementer output
  status_t          alu_flags;    // Incrementer flags
  logic [13:0]      addr_nxt;     // Effective operand address
  logic             skip_now;     // Skip condition at write phase
  logic             at_decode;    // Decode phase and free to take
  logic             take_r;
  logic             busy_r;
  logic             discard_r;
  logic [13:0]      mem_addr_r;
  logic             mem_rd_r;
  logic             mem_wr_r;
  logic [7:0]       mem_wdata_r;
  logic [7:0]       wreg_r;
  logic             wreg_we_r;
  status_t          status_r;
  logic [20:0]      pc_r;
  logic             pc_load_r;

  assign at_decode = (phase_r == PH_DECODE) && (state_r == ST_RUN);

  ////////////////////////////////////////////////////////////////////
  // Incrementer shared by all three increment kinds
  inc_alu u_alu (
    .i_operand (operand_r),
    .o_result  (alu_res),
    .o_flags   (alu_flags)
  );

  ////////////////////////////////////////////////////////////////////
  // Opcode decode of the fetched word
  always_comb begin
    kind_nxt = K_NONE;
    if (i_instr.opc == OPC_INC_FILE) begin
      kind_nxt = K_INC;                          // [RQ1]
    end else if (i_instr.opc == OPC_INC_SZERO) begin
      kind_nxt = K_SZ;                           // [RQ6]
    end else if (i_instr.opc == OPC_INC_SNZ) begin
      kind_nxt = K_SNZ;                          // [RQ7]
    end else if ({i_instr.opc, i_instr.dest, i_instr.bank}
                 == OPC_BRANCH_W1) begin
      kind_nxt = K_BR;                           // [RQ13]
    end
  end

  // Effective address; indexed mode wins over the access bank
  always_comb begin
    if (i_instr.bank) begin
      addr_nxt = {i_bank_select_register, i_instr.f}; // [RQ4]
    end else if (i_ext_en && (i_instr.f <= LIT_LIMIT)) begin
      addr_nxt = i_fsr2 + {6'h00, i_instr.f};    // [RQ5]
    end else if (i_instr.f < ACC_SPLIT) begin
      addr_nxt = {ACC_LO_BANK, i_instr.f};       // [RQ3]
    end else begin
      addr_nxt = {ACC_HI_BANK, i_instr.f};       // [RQ3]
    end
  end

  // Skip decision from the fresh result
  always_comb begin
    skip_now = 1'b0;
    if (valid_r && (kind_r == K_SZ)) begin
      skip_now = (alu_res == 8'h00);             // [RQ8]
    end else if (valid_r && (kind_r == K_SNZ)) begin
      skip_now = (alu_res != 8'h00);             // [RQ9]
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Phase counter: four clocks per instruction cycle
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      phase_r <= PH_DECODE;
    end else begin
      phase_r <= phase_r + 2'h1;                 // [RQ14]
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Decode phase: take one word-group per cycle when running
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      valid_r <= 1'b0;
      kind_r  <= K_NONE;
      instr_r <= '0;
      lit_r   <= '0;
      take_r  <= 1'b0;
    end else begin
      take_r <= at_decode && i_instr_valid;
      if (at_decode) begin
        // Nothing is taken while a follower is being discarded
        valid_r <= i_instr_valid;
        kind_r  <= i_instr_valid ? kind_nxt : K_NONE;
        instr_r <= i_instr;
        lit_r   <= {i_instr_hi[11:0], i_instr.f}; // [RQ13]
      end else if (phase_r == PH_WRITE) begin
        valid_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read phase: strobe is visible for one clock
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      mem_rd_r   <= 1'b0;
      mem_addr_r <= '0;
    end else begin
      mem_rd_r <= 1'b0;
      if (at_decode && i_instr_valid && (kind_nxt != K_NONE)
          && (kind_nxt != K_BR)) begin
        mem_rd_r   <= 1'b1;                      // [RQ14]
        mem_addr_r <= addr_nxt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Process phase: capture the operand one clock after the read
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      operand_r <= BYTE_RST;
    end else if (phase_r == PH_PROCESS && valid_r) begin
      operand_r <= i_mem_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Write phase: route the result and update flags
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      mem_wr_r    <= 1'b0;
      mem_wdata_r <= BYTE_RST;
      wreg_r      <= BYTE_RST;
      wreg_we_r   <= 1'b0;
      result_r    <= BYTE_RST;
      status_r    <= '0;
    end else begin
      mem_wr_r  <= 1'b0;
      wreg_we_r <= 1'b0;
      if (phase_r == PH_WRITE && valid_r && kind_r != K_BR
          && kind_r != K_NONE) begin
        result_r <= alu_res;
        if (instr_r.dest) begin
          mem_wr_r    <= 1'b1;                   // [RQ2]
          mem_wdata_r <= alu_res;
        end else begin
          wreg_we_r <= 1'b1;                     // [RQ2]
          wreg_r    <= alu_res;
        end
        // Skip variants leave every flag alone
        if (kind_r == K_INC) begin
          status_r <= alu_flags;                 // [RQ1]
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Program counter load for the branch
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      pc_r      <= '0;
      pc_load_r <= 1'b0;
    end else begin
      pc_load_r <= 1'b0;
      if (phase_r == PH_WRITE && valid_r && kind_r == K_BR) begin
        pc_r      <= {lit_r, 1'b0};              // [RQ13]
        pc_load_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Sequencer: inserts whole no-operation cycles
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state_r    <= ST_RUN;
      nop_left_r <= NOP_ONE;
      busy_r     <= 1'b0;
      discard_r  <= 1'b0;
    end else begin
      discard_r <= 1'b0;
      if (phase_r == PH_WRITE) begin
        unique case (state_r)
          ST_RUN: begin
            if (skip_now) begin
              // A zero count is read as a one-word follower
              state_r    <= ST_NOP;
              busy_r     <= 1'b1;
              discard_r  <= 1'b1;                // [RQ8] [RQ9]
              nop_left_r <= (i_follow_words == 2'h0) ? NOP_ONE
                            : i_follow_words;    // [RQ10] [RQ11] [RQ12]
            end else if (valid_r && kind_r == K_BR) begin
              state_r    <= ST_NOP;              // [RQ13]
              busy_r     <= 1'b1;
              nop_left_r <= NOP_ONE;
            end
          end
          ST_NOP: begin
            if (nop_left_r == NOP_ONE) begin
              state_r <= ST_RUN;
              busy_r  <= 1'b0;
            end else begin
              nop_left_r <= nop_left_r - 2'h1;   // [RQ11] [RQ12]
            end
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs straight from flip-flops
  assign o_take      = take_r;
  assign o_busy      = busy_r;
  assign o_discard   = discard_r;
  assign o_phase     = phase_r;
  assign o_mem_addr  = mem_addr_r;
  assign o_mem_rd    = mem_rd_r;
  assign o_mem_wr    = mem_wr_r;
  assign o_mem_wdata = mem_wdata_r;
  assign o_wreg      = wreg_r;
  assign o_wreg_we   = wreg_we_r;
  assign o_status    = status_r;
  assign o_pc        = pc_r;
  assign o_pc_load   = pc_load_r;

  ////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  AST_INC_VALUE: assert property ( // [RQ1]
    mem_wr_r |-> mem_wdata_r == operand_r + 8'h01)
    else $error("file write is not operand plus one");

  AST_DEST_W: assert property ( // [RQ2]
    wreg_we_r |-> !instr_r.dest && !mem_wr_r)
    else $error("W written with destination bit set");

  AST_BANKED: assert property ( // [RQ4]
    $rose(mem_rd_r) && instr_r.bank
    |-> mem_addr_r[13:8] == $past(i_bank_select_register))
    else $error("banked address ignores bank select");

  AST_ACCESS: assert property ( // [RQ3]
    $rose(mem_rd_r) && !instr_r.bank && !$past(i_ext_en)
    |-> mem_addr_r[13:8] == (instr_r.f < ACC_SPLIT ?
        ACC_LO_BANK : ACC_HI_BANK))
    else $error("access bank address wrong");

  AST_LITERAL: assert property ( // [RQ5]
    $rose(mem_rd_r) && !instr_r.bank && $past(i_ext_en)
    && instr_r.f <= LIT_LIMIT
    |-> mem_addr_r == $past(i_fsr2) + {6'h00, instr_r.f})
    else $error("indexed literal address wrong");

  AST_FLAGS_KEPT: assert property ( // [RQ6] [RQ7]
    $changed(status_r) |-> $past(kind_r) == K_INC)
    else $error("flags changed by a non-flag op");

  AST_SKIP_COND: assert property ( // [RQ8] [RQ9]
    discard_r |-> (kind_r == K_SZ && result_r == 8'h00)
    || (kind_r == K_SNZ && result_r != 8'h00))
    else $error("follower discarded on wrong result");

  AST_SKIP_ONE: assert property ( // [RQ10]
    discard_r && nop_left_r == 2'h1
    |-> busy_r [*4] ##1 !busy_r)
    else $error("one-word skip not one extra cycle");

  AST_SKIP_TWO: assert property ( // [RQ11]
    discard_r && nop_left_r == 2'h2 |-> ##7 busy_r ##1 !busy_r)
    else $error("two-word skip not two extra cycles");

  AST_SKIP_THREE: assert property ( // [RQ12]
    discard_r && nop_left_r == 2'h3 |-> ##11 busy_r ##1 !busy_r)
    else $error("three-word skip not three extra cycles");

  AST_BRANCH: assert property ( // [RQ13]
    pc_load_r |-> pc_r[0] == 1'b0 && busy_r [*4] ##1 !busy_r)
    else $error("branch not two cycles");

  AST_PHASES: assert property ( // [RQ14]
    mem_rd_r |-> phase_r == PH_READ ##3 phase_r == PH_DECODE)
    else $error("read strobe outside read phase");

  COV_INC:    cover property (mem_wr_r && kind_r == K_INC);
  COV_SKIPZ:  cover property (discard_r && kind_r == K_SZ);
  COV_SKIPNZ: cover property (discard_r && kind_r == K_SNZ);
  COV_BRANCH: cover property (pc_load_r);

endmodule

/* File: test/test_increment_skip_instruction_exec.sv */
// Self-checking bench for the increment and increment-skip executor.
// Assumes the package and the design files are compiled first; the bench
// plays fetch and data memory itself, driving all inputs at falling edges.
`timescale 1ns/1ps
module test_increment_skip_instruction_exec;
  import incr_exec_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Design signals
  logic          i_sys_clk;
  logic          i_rst;
  logic          i_instr_valid;
  byte_op_t      i_instr;
  logic [15:0]   i_instr_hi;
  logic [1:0]    i_follow_words;
  logic          o_take;
  logic          o_busy;
  logic          o_discard;
  logic [1:0]    o_phase;
  logic          i_ext_en;
  logic [5:0]    i_bank_select_register;
  logic [13:0]   i_fsr2;
  logic [13:0]   o_mem_addr;
  logic          o_mem_rd;
  logic [7:0]    i_mem_rdata;
  logic          o_mem_wr;
  logic [7:0]    o_mem_wdata;
  logic [7:0]    o_wreg;
  logic          o_wreg_we;
  status_t       o_status;
  logic [20:0]   o_pc;
  logic          o_pc_load;
  // Bench bookkeeping
  int            err_total;
  int            compares;
  int            cyc;
  status_t       exp_st;       // Flags as they should stand now

  // One comparison; case inequality so an unknown never matches
  `define CHK(got, exp) check_val((got) !== (exp), 64'(got), 64'(exp))

  incr_skip_exec u_dut (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_instr_valid(i_instr_valid),
    .i_instr(i_instr), .i_instr_hi(i_instr_hi),
    .i_follow_words(i_follow_words), .o_take(o_take), .o_busy(o_busy),
    .o_discard(o_discard), .o_phase(o_phase), .i_ext_en(i_ext_en),
    .i_bank_select_register(i_bank_select_register),
    .i_fsr2(i_fsr2), .o_mem_addr(o_mem_addr),
    .o_mem_rd(o_mem_rd), .i_mem_rdata(i_mem_rdata), .o_mem_wr(o_mem_wr),
    .o_mem_wdata(o_mem_wdata), .o_wreg(o_wreg), .o_wreg_we(o_wreg_we),
    .o_status(o_status), .o_pc(o_pc), .o_pc_load(o_pc_load)
  );

  ////////////////////////////////////////////////////////////////////////
  // 200 MHz clock
  initial begin
    i_sys_clk = 1'b0;
    forever #2.5 i_sys_clk = ~i_sys_clk;
  end

  // Hang guard: whole run needs well under 1000 cycles
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reporting
  task automatic check_val(input bit bad, input logic [63:0] got, exp);
    compares++;
    if (bad) begin
      $display("FAIL t=%0t got=%0h exp=%0h", $time, got, exp);
      err_total++;
    end
  endtask

  task automatic end_sim();
    $display("compares=%0d mismatches=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Expected operand address, worked out from the addressing rules
  function automatic logic [13:0] exp_addr(input logic a,
                                           input logic [7:0] f);
    if (!a && i_ext_en && f <= 8'h5f) begin
      return i_fsr2 + {6'h00, f};           // Index base plus offset
    end
    if (!a) begin
      return (f < 8'h60) ? {6'h00, f} : {6'h3f, f};
    end
    return {i_bank_select_register, f};
  endfunction

  // Wait at falling edges until a group would be taken at the next edge
  task automatic wait_ready();
    while (!(o_phase === PH_DECODE && o_busy === 1'b0)) begin
      @(negedge i_sys_clk);
    end
  endtask

  // Count clocks of inserted no-operation cycles; bounded wait
  task automatic count_busy(output int n);
    n = 0;
    while (o_busy === 1'b1 && n < 20) begin
      n++;
      @(negedge i_sys_clk);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // One byte-oriented instruction; memory answers with val
  task automatic run_op(input logic [5:0] opc, input logic d, a,
                        input logic [7:0] f, val, input logic [1:0] fw);
    logic [7:0] res;
    logic       hit;
    logic       skip;
    int         n;
    res  = val + 8'h01;
    hit  = (opc == 6'h0a) || (opc == 6'h0f) || (opc == 6'h12);
    skip = (opc == 6'h0f) ? (res == 8'h00) :
           (opc == 6'h12) ? (res != 8'h00) : 1'b0;
    wait_ready();
    i_instr        = byte_op_t'({opc, d, a, f});
    i_instr_valid  = 1'b1;
    i_mem_rdata    = val;
    i_follow_words = fw;
    @(negedge i_sys_clk);
    i_instr_valid = 1'b0;
    `CHK(o_take, 1'b1);
    `CHK(o_phase, 2'h1);
    `CHK(o_mem_rd, hit);
    if (hit) begin
      `CHK(o_mem_addr, exp_addr(a, f));
    end
    repeat (3) @(negedge i_sys_clk);
    `CHK(o_mem_wr, hit & d);
    `CHK(o_wreg_we, hit & !d);
    if (hit && d) begin
      `CHK(o_mem_wdata, res);
    end
    if (hit && !d) begin
      `CHK(o_wreg, res);
    end
    if (opc == 6'h0a) begin
      exp_st = status_t'({res[7], val == 8'h7f, res == 8'h00,
                          val[3:0] == 4'hf, val == 8'hff});
    end
    `CHK(o_status, exp_st);
    `CHK(o_discard, skip);
    count_busy(n);
    `CHK(n, skip ? ((fw == 2'h0) ? 4 : 4 * fw) : 0);
  endtask

  // Two-word branch with a 20-bit target
  task automatic run_branch(input logic [19:0] k);
    int n;
    wait_ready();
    i_instr       = byte_op_t'({8'hef, k[7:0]});
    i_instr_hi    = {4'hf, k[19:8]};
    i_instr_valid = 1'b1;
    @(negedge i_sys_clk);
    i_instr_valid = 1'b0;
    `CHK(o_take, 1'b1);
    repeat (3) @(negedge i_sys_clk);
    `CHK(o_pc_load, 1'b1);
    `CHK(o_pc, {k, 1'b0});
    count_busy(n);
    `CHK(n, 4);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    err_total      = 0;
    compares       = 0;
    cyc            = 0;
    exp_st         = status_t'(5'h00);
    i_rst          = 1'b1;
    i_instr_valid  = 1'b0;
    i_instr        = byte_op_t'(16'h0000);
    i_instr_hi     = 16'h0000;
    i_follow_words = 2'h0;
    i_ext_en       = 1'b0;
    i_bank_select_register = 6'h05;
    i_fsr2         = 14'h0200;
    i_mem_rdata    = 8'h00;
    repeat (2) @(negedge i_sys_clk);
    `CHK(o_phase, 2'h0);
    i_rst = 1'b0;
    // Plain increments, back to back, both destinations and banks
    run_op(6'h0a, 1'b1, 1'b0, 8'h10, 8'hff, 2'h0);
    run_op(6'h0a, 1'b0, 1'b1, 8'h22, 8'h7f, 2'h0);
    run_op(6'h0a, 1'b1, 1'b0, 8'h80, 8'h0e, 2'h0);
    run_op(6'h0a, 1'b0, 1'b0, 8'h30, 8'h41, 2'h0);
    $display("test plain_increment done");
    // Skip on zero over each follower length, then a miss
    for (int w = 0; w < 4; w++) begin
      run_op(6'h0f, 1'b1, 1'b1, 8'h40, 8'hff, w[1:0]);
    end
    run_op(6'h0f, 1'b0, 1'b0, 8'h05, 8'h41, 2'h1);
    $display("test skip_zero done");
    // Skip on nonzero over each follower length, then a miss
    for (int w = 1; w < 4; w++) begin
      run_op(6'h12, 1'b1, 1'b0, 8'h90, 8'h12, w[1:0]);
    end
    run_op(6'h12, 1'b0, 1'b1, 8'h90, 8'hff, 2'h2);
    $display("test skip_nonzero done");
    // Indexed literal offsets at the boundary, with base wrap
    i_ext_en = 1'b1;
    i_fsr2   = 14'h3fd0;
    i_bank_select_register = 6'h2a;
    run_op(6'h0a, 1'b1, 1'b0, 8'h5f, 8'h01, 2'h0);
    run_op(6'h0a, 1'b1, 1'b0, 8'h60, 8'h02, 2'h0);
    run_op(6'h0f, 1'b0, 1'b1, 8'h00, 8'h03, 2'h0);
    run_op(6'h12, 1'b1, 1'b0, 8'h00, 8'h04, 2'h1);
    $display("test indexed_addressing done");
    // Branch, then an unknown opcode that must do nothing
    run_branch(20'habcde);
    run_op(6'h3e, 1'b1, 1'b0, 8'h10, 8'h00, 2'h0);
    run_branch(20'h00001);
    $display("test branch_and_unknown done");
    end_sim();
  end

endmodule
